// *** pmt_pkg.sv ***
package pmt_pkg;

    // ********************************************************************
    // Bus geometry
    // ********************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // ********************************************************************
    // Register indices and byte addresses
    // ********************************************************************
    // Indices are not word aligned, so a byte address is four times one
    localparam logic [ADDR_W-1:0] IDX_FLAG = 12'h00C;
    localparam logic [ADDR_W-1:0] IDX_COUNT = 12'h011;
    localparam logic [ADDR_W-1:0] IDX_CONTROL = 12'h012;
    localparam logic [ADDR_W-1:0] IDX_ENABLE = 12'h08C;
    localparam logic [ADDR_W-1:0] IDX_PERIOD = 12'h092;
    localparam logic [ADDR_W-1:0] ADDR_FLAG = IDX_FLAG << 2;
    localparam logic [ADDR_W-1:0] ADDR_COUNT = IDX_COUNT << 2;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = IDX_CONTROL << 2;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = IDX_ENABLE << 2;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD = IDX_PERIOD << 2;

    // ********************************************************************
    // Field layout
    // ********************************************************************
    localparam int PRE_LSB = 0;
    localparam int PRE_W = 2;
    localparam int ON_BIT = 2;
    localparam int POST_LSB = 3;
    localparam int POST_W = 4;
    localparam int MATCH_BIT = 1;
    localparam logic [REG_W-1:0] CONTROL_MASK = 8'h7F;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [REG_W-1:0] COUNT_RESET = 8'h00;
    localparam logic [REG_W-1:0] CONTROL_RESET = 8'h00;
    localparam logic [REG_W-1:0] PERIOD_RESET = 8'hFF;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLKS_PER_INSTR = 4;
    localparam int PRE_CNT_W = 4;
    localparam logic [PRE_CNT_W-1:0] PRE_TERM_1 = 4'h0;
    localparam logic [PRE_CNT_W-1:0] PRE_TERM_4 = 4'h3;
    localparam logic [PRE_CNT_W-1:0] PRE_TERM_16 = 4'hF;

endpackage : pmt_pkg

// *** scaler_if.sv ***
`timescale 1ns/10ps
// Link between the timer core and one of its event dividers
interface scaler_if #(
    parameter int SEL_W = 2
);
    logic step;
    logic clear;
    logic [SEL_W-1:0] sel;
    logic done;

    modport owner (output step, output clear, output sel, input done);
    modport scaler (input step, input clear, input sel, output done);
endinterface : scaler_if

// *** input_prescaler.sv ***
`timescale 1ns/10ps
module input_prescaler (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link to the timer core
    scaler_if.scaler link
);

    logic [pmt_pkg::PRE_CNT_W-1:0] cnt_reg;
    logic [pmt_pkg::PRE_CNT_W-1:0] term;

    // Terminal count from the two select bits, upper bit wins
    always_comb begin
        if (link.sel[1]) begin
            term = pmt_pkg::PRE_TERM_16;
        end else if (link.sel[0]) begin
            term = pmt_pkg::PRE_TERM_4;
        end else begin
            term = pmt_pkg::PRE_TERM_1;
        end
    end

    assign link.done = link.step && !link.clear && (cnt_reg == term);

    // Divider count; clear beats a step
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (link.clear) begin
            cnt_reg <= '0;
        end else if (link.step) begin
            cnt_reg <= (cnt_reg >= term) ? '0 : cnt_reg + 1'b1;
        end
    end

endmodule : input_prescaler

// *** match_postscaler.sv ***
`timescale 1ns/10ps
module match_postscaler (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link to the timer core
    scaler_if.scaler link
);

    logic [pmt_pkg::POST_W-1:0] cnt_reg;

    // Ratio is select plus one
    assign link.done = link.step && !link.clear && (cnt_reg == link.sel);

    // A lowered select while counting above it wraps at the next step
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (link.clear) begin
            cnt_reg <= '0;
        end else if (link.step) begin
            cnt_reg <= (cnt_reg >= link.sel) ? '0 : cnt_reg + 1'b1;
        end
    end

endmodule : match_postscaler

// *** period_match_timer_8bit.sv ***
// Local design decision: the APB register port.
`timescale 1ns/10ps

// ************************************************************************
// Period match timer, eight bit count
// ************************************************************************

// Notes on behaviour
// - While on, the count steps once per prescaler output fed by clk/4.
// - Prescale select 00 divides by 1, 01 by 4, 1x by 16.
// - Postscale select bits 6..3 divide match events by the value plus one.
// - Control bit 2 turns the timer on; while off the count holds.
// - The count runs from zero to the period and then returns to zero.
// - Each match steps the postscaler, whose output sets flag bit 1.
// - Writes to count or control and any reset clear both scalers.
// - A control write leaves the count value as it was.
// - The count is read and write and resets to zero.
// - The period is read and write and resets to all ones.
// - The count and the match event are offered to the PWM unit.
// - Control bit 7 reads zero and ignores writes.
module period_match_timer_8bit (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pmt_pkg::ADDR_W-1:0] paddr,
    input wire logic [pmt_pkg::DATA_W-1:0] pwdata,
    output logic [pmt_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Time base for the PWM unit
    output logic [pmt_pkg::REG_W-1:0] pwm_count,
    output logic pwm_period_match,
    // Match interrupt request
    output logic match_irq
);

    // ********************************************************************
    // Declarations
    // ********************************************************************
    // Register picked by the address
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_FLAG,
        SEL_COUNT,
        SEL_CONTROL,
        SEL_ENABLE,
        SEL_PERIOD
    } reg_sel_t;

    // Width of the quarter divider
    localparam int PHASE_W = $clog2(pmt_pkg::CLKS_PER_INSTR);
    localparam logic [PHASE_W-1:0] PHASE_LAST =
        PHASE_W'(pmt_pkg::CLKS_PER_INSTR - 1);

    reg_sel_t sel;
    logic [pmt_pkg::REG_W-1:0] count_reg;
    logic [pmt_pkg::REG_W-1:0] count_next;
    logic [pmt_pkg::REG_W-1:0] control_reg;
    logic [pmt_pkg::REG_W-1:0] period_reg;
    logic flag_reg;
    logic flag_next;
    logic enable_reg;
    logic enable_next;
    logic [PHASE_W-1:0] phase_reg;
    logic instr_tick;
    logic setup;
    logic access;
    logic wr_en;
    logic wr_count;
    logic wr_control;
    logic wr_period;
    logic wr_flag;
    logic wr_enable;
    logic [pmt_pkg::REG_W-1:0] wbyte;
    logic [pmt_pkg::REG_W-1:0] rbyte;
    logic timer_on;
    logic match_event;
    logic flag_set;
    logic [pmt_pkg::DATA_W-1:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic pwm_match_reg;
    logic irq_reg;

    // One link per divider
    scaler_if #(.SEL_W(pmt_pkg::PRE_W)) pre_link ();
    scaler_if #(.SEL_W(pmt_pkg::POST_W)) post_link ();

    // ********************************************************************
    // Address decode
    // ********************************************************************
    // Only the word address matters; the two low bits are ignored
    always_comb begin
        unique case ({paddr[pmt_pkg::ADDR_W-1:2], 2'b00})
            pmt_pkg::ADDR_FLAG: sel = SEL_FLAG;
            pmt_pkg::ADDR_COUNT: sel = SEL_COUNT;
            pmt_pkg::ADDR_CONTROL: sel = SEL_CONTROL;
            pmt_pkg::ADDR_ENABLE: sel = SEL_ENABLE;
            pmt_pkg::ADDR_PERIOD: sel = SEL_PERIOD;
            default: sel = SEL_NONE;
        endcase
    end

    // Phase strobes of the transfer
    assign setup = psel && !penable && !pready_reg;
    assign access = psel && penable && pready_reg;
    assign wr_en = access && pwrite;
    assign wbyte = pwdata[pmt_pkg::REG_W-1:0];

    // Per register write strobes, all taken in the completing cycle
    assign wr_count = wr_en && (sel == SEL_COUNT);
    assign wr_control = wr_en && (sel == SEL_CONTROL);
    assign wr_period = wr_en && (sel == SEL_PERIOD);
    assign wr_flag = wr_en && (sel == SEL_FLAG);
    assign wr_enable = wr_en && (sel == SEL_ENABLE);

    // ********************************************************************
    // Read mux
    // ********************************************************************
    // Unimplemented flag and enable bits read as zero
    always_comb begin
        rbyte = '0;
        unique case (sel)
            SEL_FLAG: rbyte[pmt_pkg::MATCH_BIT] = flag_reg;
            SEL_COUNT: rbyte = count_reg;
            SEL_CONTROL: rbyte = control_reg & pmt_pkg::CONTROL_MASK;
            SEL_ENABLE: rbyte[pmt_pkg::MATCH_BIT] = enable_reg;
            SEL_PERIOD: rbyte = period_reg;
            SEL_NONE: rbyte = '0;
        endcase
    end

    // ********************************************************************
    // APB answer
    // ********************************************************************
    // Ready one cycle after setup, so every access has no wait state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
        end
    end

    // Read data caught at setup; the master holds the address anyway
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_reg <= {{(pmt_pkg::DATA_W - pmt_pkg::REG_W){1'b0}}, rbyte};
        end else if (access) begin
            prdata_reg <= 32'h0000_0000;
        end
    end

    // Unmapped address answers with an error and no effect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= setup && (sel == SEL_NONE);
        end
    end

    // ********************************************************************
    // Instruction clock
    // ********************************************************************
    // Free running quarter divider; not cleared by writes, so the first
    // step after a write may come early by up to three clocks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= '0;
        end else begin
            phase_reg <= phase_reg + 1'b1;
        end
    end

    // One tick each fourth clock
    assign instr_tick = (phase_reg == PHASE_LAST);

    // ********************************************************************
    // Control register
    // ********************************************************************
    // Run bit gates the count
    assign timer_on = control_reg[pmt_pkg::ON_BIT];

    // Bit 7 is never stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_reg <= pmt_pkg::CONTROL_RESET;
        end else if (wr_control) begin
            control_reg <= wbyte & pmt_pkg::CONTROL_MASK;
        end
    end

    // ********************************************************************
    // Period register
    // ********************************************************************
    // Period, reset to all ones
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_reg <= pmt_pkg::PERIOD_RESET;
        end else if (wr_period) begin
            period_reg <= wbyte;
        end
    end

    // ********************************************************************
    // Scalers
    // ********************************************************************
    // Prescaler steps on the instruction clock only while on
    assign pre_link.step = instr_tick && timer_on;
    assign pre_link.clear = wr_count || wr_control;
    assign pre_link.sel = control_reg[pmt_pkg::PRE_LSB +: pmt_pkg::PRE_W];

    // A match is the increment that finds the count at the period
    assign match_event = pre_link.done && (count_reg == period_reg);

    // Postscaler steps on each match
    assign post_link.step = match_event;
    assign post_link.clear = wr_count || wr_control;
    assign post_link.sel = control_reg[pmt_pkg::POST_LSB +: pmt_pkg::POST_W];

    // Ratio reached sets the flag
    assign flag_set = post_link.done;

    // Input divider
    input_prescaler u_prescaler (
        .clk(clk),
        .rst_n(rst_n),
        .link(pre_link)
    );

    // Match divider
    match_postscaler u_postscaler (
        .clk(clk),
        .rst_n(rst_n),
        .link(post_link)
    );

    // ********************************************************************
    // Count register
    // ********************************************************************
    // A software write beats a step in the same cycle; control writes
    // deliberately leave the count alone
    always_comb begin
        count_next = count_reg;
        if (wr_count) begin
            count_next = wbyte;
        end else if (pre_link.done) begin
            if (count_reg == period_reg) begin
                count_next = pmt_pkg::COUNT_RESET;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
    end

    // Count state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= pmt_pkg::COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    // ********************************************************************
    // Flag and enable
    // ********************************************************************
    // Writing zero to the flag bit clears it, but a set in that same
    // cycle wins so no match is lost
    always_comb begin
        flag_next = flag_reg;
        if (wr_flag && !wbyte[pmt_pkg::MATCH_BIT]) begin
            flag_next = 1'b0;
        end
        if (flag_set) begin
            flag_next = 1'b1;
        end
    end

    // Flag state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Enable bit
    always_comb begin
        enable_next = enable_reg;
        if (wr_enable) begin
            enable_next = wbyte[pmt_pkg::MATCH_BIT];
        end
    end

    // Enable state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg <= 1'b0;
        end else begin
            enable_reg <= enable_next;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    // Request follows flag and enable with one cycle of lag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= flag_reg && enable_reg;
        end
    end

    // Match pulse for the PWM unit, one clock wide
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_match_reg <= 1'b0;
        end else begin
            pwm_match_reg <= match_event && !wr_count;
        end
    end

    // Outputs, all from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pwm_count = count_reg;
    assign pwm_period_match = pwm_match_reg;
    assign match_irq = irq_reg;

endmodule : period_match_timer_8bit

// *** period_match_timer_8bit_props.sv ***
`timescale 1ns/10ps
// ********************************************************************
// Port checker for the period match timer
// ********************************************************************
module period_match_timer_8bit_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pmt_pkg::ADDR_W-1:0] paddr,
    input wire logic [pmt_pkg::DATA_W-1:0] pwdata,
    input wire logic [pmt_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Time base and request
    input wire logic [pmt_pkg::REG_W-1:0] pwm_count,
    input wire logic pwm_period_match,
    input wire logic match_irq
);
    logic acc;
    logic wr_count;
    logic wr_flag;
    logic wr_en;
    logic hit_map;
    logic en_reg;
    logic [pmt_pkg::REG_W-1:0] ctl_reg;
    logic [pmt_pkg::REG_W-1:0] per_reg;

    function automatic logic at(input logic [11:0] a, input logic [11:0] b);
        return a[11:2] == b[11:2];
    endfunction : at

    // Decoded completed writes
    assign acc = psel && penable && pready;
    assign wr_count = acc && pwrite && at(paddr, pmt_pkg::ADDR_COUNT);
    assign wr_flag = acc && pwrite && at(paddr, pmt_pkg::ADDR_FLAG);
    assign wr_en = acc && pwrite && at(paddr, pmt_pkg::ADDR_ENABLE);
    assign hit_map = at(paddr, pmt_pkg::ADDR_FLAG) ||
        at(paddr, pmt_pkg::ADDR_COUNT) || at(paddr, pmt_pkg::ADDR_CONTROL) ||
        at(paddr, pmt_pkg::ADDR_ENABLE) || at(paddr, pmt_pkg::ADDR_PERIOD);

    // Shadows of the writable settings, updated at the same edge as the block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_reg <= 8'h00;
        end else if (acc && pwrite && at(paddr, pmt_pkg::ADDR_CONTROL)) begin
            ctl_reg <= pwdata[7:0];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            per_reg <= 8'hFF;
        end else if (acc && pwrite && at(paddr, pmt_pkg::ADDR_PERIOD)) begin
            per_reg <= pwdata[7:0];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_reg <= 1'b0;
        end else if (wr_en) begin
            en_reg <= pwdata[1];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_ready_after_setup: assert property (
        psel && !penable |=> pready) else $error("no pready after setup");
    a_ready_pulse: assert property (
        pready |=> !pready) else $error("pready longer than one cycle");
    a_upper_zero: assert property (
        pready |-> prdata[31:8] == 24'h00_0000) else $error("upper bits set");
    a_err_unmapped: assert property (
        pready |-> pslverr == !hit_map) else $error("wrong pslverr");
    a_ctl_bit_zero: assert property (
        pready && !pwrite && at(paddr, pmt_pkg::ADDR_CONTROL) |-> !prdata[7])
        else $error("control bit 7 reads one");
    a_count_frozen_off: assert property (
        $changed(pwm_count) && !$past(wr_count) |-> $past(ctl_reg[2]))
        else $error("count moved while off");
    a_count_steps: assert property (
        $changed(pwm_count) && !$past(wr_count) |-> pwm_count ==
        (($past(pwm_count) == $past(per_reg)) ? 8'h00 :
        8'($past(pwm_count) + 8'h01))) else $error("bad count step");
    a_match_at_zero: assert property (
        pwm_period_match && !$past(wr_count) |-> pwm_count == 8'h00)
        else $error("match away from zero");
    a_match_pulse: assert property (
        pwm_period_match |=> !pwm_period_match) else $error("long match");
    a_irq_needs_enable: assert property (
        match_irq |-> $past(en_reg)) else $error("irq without enable");
    a_irq_holds: assert property (
        $fell(match_irq) |-> $past(wr_flag, 2) || $past(wr_en, 2))
        else $error("irq dropped without software");

    // Main scenarios reached
    c_match: cover property (pwm_period_match);
    c_irq: cover property ($rose(match_irq));
    c_err: cover property (pready && pslverr);
    c_step: cover property ($changed(pwm_count));
endmodule : period_match_timer_8bit_props

bind period_match_timer_8bit period_match_timer_8bit_props i_props (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_count(pwm_count),
    .pwm_period_match(pwm_period_match), .match_irq(match_irq));

// *** period_match_timer_8bit_bench.sv ***
`timescale 1ns/10ps
// ********************************************************************
// Self-checking bench for the period match timer
// ********************************************************************
module period_match_timer_8bit_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [pmt_pkg::ADDR_W-1:0] paddr = 12'h000;
    logic [pmt_pkg::DATA_W-1:0] pwdata = 32'h0000_0000;
    logic [pmt_pkg::DATA_W-1:0] prdata;
    logic [pmt_pkg::DATA_W-1:0] rdata;
    logic pready;
    logic pslverr;
    logic err_seen;
    logic [pmt_pkg::REG_W-1:0] pwm_count;
    logic pwm_period_match;
    logic match_irq;
    int mismatches = 0;
    int n_compared = 0;
    int pulses = 0;
    int n;
    int base;
    logic [11:0] addrs [5] = '{12'h030, 12'h044, 12'h048, 12'h230, 12'h248};
    logic [31:0] resets [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_00FF};
    int posts [4] = '{0, 1, 7, 15};

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Match pulses seen, for the postscaler ratio
    always @(posedge clk) begin
        if (pwm_period_match === 1'b1) begin
            pulses <= pulses + 1;
        end
    end

    period_match_timer_8bit i_period_match_timer_8bit (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pwm_count(pwm_count),
        .pwm_period_match(pwm_period_match), .match_irq(match_irq));

    task final_report;
        $display("compared %0d mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task check(input string what, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One APB transfer; holds the request until pready is sampled high
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rdata = prdata;
        err_seen = pslverr;
        check("pready", 32'(pready), 32'h0000_0001);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task rd(input logic [11:0] a);
        xfer(1'b0, a, 32'h0000_0000);
    endtask : rd

    // Cycles until the count leaves the given value
    task gap(input logic [7:0] v, output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (pwm_count === v && c < 2000);
    endtask : gap

    task wait_for(input int w, output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while ((w ? match_irq : pwm_period_match) !== 1'b1 && c < 2000);
    endtask : wait_for

    // Cut a hang short
    initial begin
        #100000;
        mismatches++;
        $display("BAD watchdog expected finish seen hang");
        final_report();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values and an unmapped word
        foreach (addrs[i]) begin
            rd(addrs[i]);
            check("reset value", rdata, resets[i]);
            check("mapped err", 32'(err_seen), 32'h0000_0000);
        end
        rd(12'h004);
        check("unmapped err", 32'(err_seen), 32'h0000_0001);
        wr(12'h004, 32'h0000_00FF);
        check("unmapped wr err", 32'(err_seen), 32'h0000_0001);
        $display("test reset done");
        // Access kinds; the count must hold while off
        wr(pmt_pkg::ADDR_COUNT, 32'h0000_005A);
        repeat (40) @(posedge clk);
        rd(pmt_pkg::ADDR_COUNT);
        check("count held", rdata, 32'h0000_005A);
        wr(pmt_pkg::ADDR_CONTROL, 32'h0000_00F8);
        rd(pmt_pkg::ADDR_CONTROL);
        check("control", rdata, 32'h0000_0078);
        rd(pmt_pkg::ADDR_COUNT);
        check("count after ctl", rdata, 32'h0000_005A);
        wr(pmt_pkg::ADDR_PERIOD, 32'h0000_003C);
        rd(pmt_pkg::ADDR_PERIOD);
        check("period", rdata, 32'h0000_003C);
        $display("test access done");
        // Each prescale code gives its step spacing
        wr(pmt_pkg::ADDR_PERIOD, 32'h0000_00FF);
        for (int p = 0; p < 4; p++) begin
            wr(pmt_pkg::ADDR_CONTROL, 32'(4 + p));
            gap(pwm_count, n);
            gap(pwm_count, n);
            check("gap", 32'(n), 32'(p == 0 ? 4 : p == 1 ? 16 : 64));
        end
        $display("test prescale done");
        // Wrap at the period
        wr(pmt_pkg::ADDR_CONTROL, 32'h0000_0000);
        wr(pmt_pkg::ADDR_COUNT, 32'h0000_0000);
        wr(pmt_pkg::ADDR_PERIOD, 32'h0000_0003);
        wr(pmt_pkg::ADDR_CONTROL, 32'h0000_0004);
        wait_for(0, n);
        wait_for(0, n);
        check("wrap spacing", 32'(n), 32'h0000_0010);
        check("wrap value", 32'(pwm_count), 32'h0000_0000);
        $display("test wrap done");
        // Postscale ratios, starting from a cleared postscaler each time
        wr(pmt_pkg::ADDR_PERIOD, 32'h0000_0000);
        wr(pmt_pkg::ADDR_ENABLE, 32'h0000_0002);
        foreach (posts[i]) begin
            wr(pmt_pkg::ADDR_CONTROL, 32'h0000_0000);
            wr(pmt_pkg::ADDR_FLAG, 32'h0000_0000);
            wr(pmt_pkg::ADDR_CONTROL, 32'((posts[i] << 3) + 4));
            base = pulses;
            wait_for(1, n);
            check("ratio", 32'(pulses - base), 32'(posts[i] + 1));
        end
        // The flag stays until cleared, the request needs the enable
        wr(pmt_pkg::ADDR_CONTROL, 32'h0000_0000);
        repeat (20) @(posedge clk);
        rd(pmt_pkg::ADDR_FLAG);
        check("flag held", rdata, 32'h0000_0002);
        check("irq held", 32'(match_irq), 32'h0000_0001);
        wr(pmt_pkg::ADDR_ENABLE, 32'h0000_0000);
        repeat (3) @(posedge clk);
        check("irq masked", 32'(match_irq), 32'h0000_0000);
        wr(pmt_pkg::ADDR_FLAG, 32'h0000_0000);
        rd(pmt_pkg::ADDR_FLAG);
        check("flag cleared", rdata, 32'h0000_0000);
        $display("test postscale done");
        // A count write restarts the prescaler from zero
        wr(pmt_pkg::ADDR_PERIOD, 32'h0000_00FF);
        wr(pmt_pkg::ADDR_CONTROL, 32'h0000_0006);
        repeat (37) @(posedge clk);
        wr(pmt_pkg::ADDR_COUNT, 32'h0000_0010);
        gap(8'h10, n);
        check("clear gap", 32'(n >= 58 && n <= 66), 32'h0000_0001);
        check("after clear", 32'(pwm_count), 32'h0000_0011);
        $display("test scaler clear done");
        // A second reset in mid-run
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(pmt_pkg::ADDR_COUNT);
        check("count rerun", rdata, 32'h0000_0000);
        rd(pmt_pkg::ADDR_PERIOD);
        check("period rerun", rdata, 32'h0000_00FF);
        $display("test second reset done");
        final_report();
    end
endmodule : period_match_timer_8bit_bench
